//--- design/pps_top.sv
// Added by the designer: the AXI4-Lite interface to the registers and the placing of the registers.
`default_nettype none
module pps_top #(
   parameter logic [7:0] WAIT_MAX = pps_pkg::WAIT_LIMIT  // Wait timeout cycles
) (
   input  wire logic        clk_sys,                        // System clock
   input  wire logic        nrst,                           // Sync reset, low
   input  wire logic [3:0]  s_axi_awaddr,                   // Write address
   input  wire logic        s_axi_awvalid,                  // Write address valid
   output logic             s_axi_awready,                  // Write address ready
   input  wire logic [31:0] s_axi_wdata,                    // Write data
   input  wire logic [3:0]  s_axi_wstrb,                    // Byte enables
   input  wire logic        s_axi_wvalid,                   // Write data valid
   output logic             s_axi_wready,                   // Write data ready
   output logic [1:0]       s_axi_bresp,                    // Write response
   output logic             s_axi_bvalid,                   // Write response valid
   input  wire logic        s_axi_bready,                   // Response ready
   input  wire logic [3:0]  s_axi_araddr,                   // Read address
   input  wire logic        s_axi_arvalid,                  // Read address valid
   output logic             s_axi_arready,                  // Read address ready
   output logic [31:0]      s_axi_rdata,                    // Read data
   output logic [1:0]       s_axi_rresp,                    // Read response
   output logic             s_axi_rvalid,                   // Read valid
   input  wire logic        s_axi_rready,                   // Read ready
   input  wire logic [7:0]  port_data_lines_i,              // Data lines in
   output logic [7:0]       port_data_lines_o,              // Data lines out
   output logic             port_data_lines_oe,             // Data lines drive
   output logic             feed_or_data_strobe_pin_o,      // Feed/data strobe
   output logic             feed_or_data_strobe_pin_oe,     // Its enable
   output logic             select_or_address_strobe_pin_o, // Select/addr strobe
   output logic             select_or_address_strobe_pin_oe,// Its enable
   output logic             valid_or_write_strobe_pin_o,    // Valid/write strobe
   output logic             valid_or_write_strobe_pin_oe,   // Its enable
   output logic             init_pin_o,                     // Initialize
   output logic             init_pin_oe,                    // Its enable
   input  wire logic        ack_n,                          // Acknowledge, low
   input  wire logic        busy_or_wait_n,                 // Busy / wait low
   input  wire logic        error_n,                        // Error, low
   input  wire logic        paper_out_input,                // Paper out
   input  wire logic        printer_selected_input          // Printer selected
);
   logic [7:0] wr_byte;
   logic [7:0] rd_byte;
   logic [3:0] wr_addr;
   logic [3:0] rd_addr;
   logic       wr_en;
   logic       rd_en;
   logic       rd_ok;
   pps_axil u_axil (
      .clk_sys (clk_sys),
      .nrst    (nrst),
      .awaddr  (s_axi_awaddr),
      .awvalid (s_axi_awvalid),
      .awready (s_axi_awready),
      .wdata   (s_axi_wdata),
      .wstrb   (s_axi_wstrb),
      .wvalid  (s_axi_wvalid),
      .wready  (s_axi_wready),
      .bresp   (s_axi_bresp),
      .bvalid  (s_axi_bvalid),
      .bready  (s_axi_bready),
      .araddr  (s_axi_araddr),
      .arvalid (s_axi_arvalid),
      .arready (s_axi_arready),
      .rdata   (s_axi_rdata),
      .rresp   (s_axi_rresp),
      .rvalid  (s_axi_rvalid),
      .rready  (s_axi_rready),
      .wr_en   (wr_en),
      .wr_addr (wr_addr),
      .wr_byte (wr_byte),
      .rd_en   (rd_en),
      .rd_addr (rd_addr),
      .rd_byte (rd_byte),
      .rd_ok   (rd_ok)
   );
   logic [7:0]          data_out;
   logic [7:0]          data_in;
   logic [7:0]          ctrl;
   logic                epp_write;
   logic                epp_addr;
   logic                epp_timeout;
   logic [7:0]          wait_cnt;
   pps_pkg::pps_state_e state;
   pps_pkg::pps_state_e next_state;
   wire wr_data = wr_en && (wr_addr == pps_pkg::ADDR_DATA);
   wire wr_ctrl = wr_en && (wr_addr == pps_pkg::ADDR_CTRL);
   wire wr_epp  = wr_en && (wr_addr == pps_pkg::ADDR_EPP);
   wire epp_mode = ctrl[pps_pkg::CTL_EPP];
   wire go      = wr_epp && wr_byte[pps_pkg::EPP_GO] && epp_mode && (state == pps_pkg::PPS_IDLE);
   wire abort   = (wr_epp && wr_byte[pps_pkg::EPP_ABORT]) || !epp_mode;
   wire wait_on = !busy_or_wait_n;
   wire too_long = (wait_cnt >= WAIT_MAX);
   wire in_cycle = (state != pps_pkg::PPS_IDLE);
   // Cycle sequence: setup, strobe until wait releases or the wait count reaches WAIT_MAX, done
   always_comb begin
      next_state = state;
      unique case (state)
         pps_pkg::PPS_IDLE:   if (go) next_state = pps_pkg::PPS_SETUP;
         pps_pkg::PPS_SETUP:  next_state = pps_pkg::PPS_STROBE;
         pps_pkg::PPS_STROBE: if (!wait_on || too_long) next_state = pps_pkg::PPS_DONE;
         pps_pkg::PPS_DONE:   next_state = pps_pkg::PPS_IDLE;
      endcase
      if (abort && in_cycle) next_state = pps_pkg::PPS_IDLE;
   end
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         state       <= pps_pkg::PPS_IDLE;
         data_out    <= 8'h00;
         data_in     <= 8'h00;
         ctrl        <= pps_pkg::CTRL_RESET;
         epp_write   <= 1'b0;
         epp_addr    <= 1'b0;
         epp_timeout <= 1'b0;
         wait_cnt    <= 8'h00;
      end else begin
         state <= next_state;
         if (wr_data) data_out <= wr_byte;
         if (wr_ctrl) ctrl <= wr_byte;
         if (go) begin
            epp_write <= wr_byte[pps_pkg::EPP_WRITE];
            epp_addr  <= wr_byte[pps_pkg::EPP_ADDR];
         end
         wait_cnt <= (state == pps_pkg::PPS_STROBE) ? wait_cnt + 8'h01 : 8'h00;
         // Set wins over a clear by a new start
         if (state == pps_pkg::PPS_STROBE && wait_on && too_long) epp_timeout <= 1'b1;
         else if (go) epp_timeout <= 1'b0;
         // Read data caught as the strobe ends
         if (state == pps_pkg::PPS_STROBE && !wait_on && !epp_write) data_in <= port_data_lines_i;
         else if (!epp_mode && ctrl[pps_pkg::CTL_INPUT]) data_in <= port_data_lines_i;
      end
   end
   // Pin levels and enables
   wire strobing   = (state == pps_pkg::PPS_STROBE);
   wire epp_wr_lvl = !(in_cycle && epp_write);
   wire epp_data_cycle_strobe_lvl  = !(strobing && !epp_addr);
   wire epp_address_cycle_strobe_lvl  = !(strobing && epp_addr);
   wire feed_lvl   = epp_mode ? epp_data_cycle_strobe_lvl : !ctrl[pps_pkg::CTL_FEED];
   wire feed_drv   = epp_mode || ctrl[pps_pkg::CTL_FEED];
   wire sel_lvl    = epp_mode ? epp_address_cycle_strobe_lvl : !ctrl[pps_pkg::CTL_SELECT];
   wire sel_drv    = epp_mode || ctrl[pps_pkg::CTL_SELECT];
   wire stb_lvl    = epp_mode ? epp_wr_lvl : !ctrl[pps_pkg::CTL_STROBE];
   wire stb_drv    = epp_mode || ctrl[pps_pkg::CTL_STROBE];
   wire init_lvl   = 1'b0;
   wire init_drv   = !ctrl[pps_pkg::CTL_INIT];
   wire data_drv   = epp_mode ? (in_cycle && epp_write) : !ctrl[pps_pkg::CTL_INPUT];
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         port_data_lines_o  <= 8'h00;
         port_data_lines_oe <= 1'b0;
      end else begin
         port_data_lines_o  <= data_out;
         port_data_lines_oe <= data_drv;
      end
   end
   pps_pin u_feed (.clk_sys(clk_sys), .nrst(nrst), .level(feed_lvl), .drive(feed_drv),
                   .pin_o(feed_or_data_strobe_pin_o), .pin_oe(feed_or_data_strobe_pin_oe));
   pps_pin u_sel  (.clk_sys(clk_sys), .nrst(nrst), .level(sel_lvl), .drive(sel_drv),
                   .pin_o(select_or_address_strobe_pin_o), .pin_oe(select_or_address_strobe_pin_oe));
   pps_pin u_stb  (.clk_sys(clk_sys), .nrst(nrst), .level(stb_lvl), .drive(stb_drv),
                   .pin_o(valid_or_write_strobe_pin_o), .pin_oe(valid_or_write_strobe_pin_oe));
   pps_pin u_init (.clk_sys(clk_sys), .nrst(nrst), .level(init_lvl), .drive(init_drv),
                   .pin_o(init_pin_o), .pin_oe(init_pin_oe));
   // Status: raw printer lines plus cycle state
   wire [7:0] status = {busy_or_wait_n, ack_n, paper_out_input, printer_selected_input,
                        error_n, epp_timeout, in_cycle, 1'b0};
   assign rd_ok = (rd_addr[1:0] == 2'h0);
   assign rd_byte = (rd_addr == pps_pkg::ADDR_DATA)   ? data_in :
                    (rd_addr == pps_pkg::ADDR_STATUS) ? status  :
                    (rd_addr == pps_pkg::ADDR_CTRL)   ? ctrl    :
                    (rd_addr == pps_pkg::ADDR_EPP)    ? {5'h00, epp_addr, epp_write, 1'b0} : 8'h00;
   wire unused_rd = rd_en;
   AST_FEED_FLOAT: assert property (@(posedge clk_sys) disable iff (!nrst)
      !epp_mode && !ctrl[pps_pkg::CTL_FEED] |=> !feed_or_data_strobe_pin_oe)
      else $error("Feed pin driven while its bit is zero");
   AST_INIT_FLOAT: assert property (@(posedge clk_sys) disable iff (!nrst)
      ctrl[pps_pkg::CTL_INIT] |=> !init_pin_oe)
      else $error("Init pin driven while its bit is one");
   AST_SEL_FLOAT: assert property (@(posedge clk_sys) disable iff (!nrst)
      !epp_mode && !ctrl[pps_pkg::CTL_SELECT] |=> !select_or_address_strobe_pin_oe)
      else $error("Select pin driven while its bit is zero");
   AST_STB_DRIVE: assert property (@(posedge clk_sys) disable iff (!nrst)
      !epp_mode && ctrl[pps_pkg::CTL_STROBE] |=> valid_or_write_strobe_pin_oe && !valid_or_write_strobe_pin_o)
      else $error("Data-valid strobe not driven low");
   AST_FEED_LOW: assert property (@(posedge clk_sys) disable iff (!nrst)
      !epp_mode && ctrl[pps_pkg::CTL_FEED] |=> !feed_or_data_strobe_pin_o)
      else $error("Feed request not low");
   AST_WAIT_HOLD: assert property (@(posedge clk_sys) disable iff (!nrst)
      strobing && wait_on && !too_long && !abort |=> strobing)
      else $error("Cycle closed while wait asserted");
   AST_ABORT_HIGH: assert property (@(posedge clk_sys) disable iff (!nrst)
      epp_mode && in_cycle && abort |=> ##1 feed_or_data_strobe_pin_o && select_or_address_strobe_pin_o
      && valid_or_write_strobe_pin_o)
      else $error("Strobes not high after abort");
   AST_ORDER: assert property (@(posedge clk_sys) disable iff (!nrst)
      $rose(strobing) |-> $past(state) == pps_pkg::PPS_SETUP)
      else $error("Strobe without setup");
endmodule
`default_nettype wire

//--- design/pps_pkg.sv
`default_nettype none
package pps_pkg;
   localparam logic [3:0] ADDR_DATA   = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h4;
   localparam logic [3:0] ADDR_CTRL   = 4'h8;
   localparam logic [3:0] ADDR_EPP    = 4'hc;
   // Control register fields
   localparam int CTL_STROBE = 0;
   localparam int CTL_FEED   = 1;
   localparam int CTL_INIT   = 2;
   localparam int CTL_SELECT = 3;
   localparam int CTL_INPUT  = 5;
   localparam int CTL_EPP    = 7;
   localparam logic [7:0] CTRL_RESET = 8'h04;
   // Enhanced-cycle command register fields
   localparam int EPP_GO    = 0;
   localparam int EPP_WRITE = 1;
   localparam int EPP_ADDR  = 2;
   localparam int EPP_ABORT = 3;
   localparam int          CLK_HZ        = 10_000_000;
   localparam int          WAIT_LIMIT_NS = 10_000;
   localparam logic [7:0]  WAIT_LIMIT    = 8'((WAIT_LIMIT_NS * (CLK_HZ / 1_000_000)) / 1000);
   localparam logic [1:0]  AXI_OKAY      = 2'h0;
   localparam logic [1:0]  AXI_SLVERR    = 2'h2;
   typedef enum logic [1:0] {
      PPS_IDLE   = 2'b00,
      PPS_SETUP  = 2'b01,
      PPS_STROBE = 2'b10,
      PPS_DONE   = 2'b11
   } pps_state_e;
endpackage
`default_nettype wire

//--- design/pps_axil.sv
`default_nettype none
module pps_axil (
   input  wire logic        clk_sys,  // System clock
   input  wire logic        nrst,     // Sync reset, low
   input  wire logic [3:0]  awaddr,   // Write address
   input  wire logic        awvalid,  // Write address valid
   output logic             awready,  // Write address ready
   input  wire logic [31:0] wdata,    // Write data
   input  wire logic [3:0]  wstrb,    // Byte enables
   input  wire logic        wvalid,   // Write data valid
   output logic             wready,   // Write data ready
   output logic [1:0]       bresp,    // Write response
   output logic             bvalid,   // Write response valid
   input  wire logic        bready,   // Response ready
   input  wire logic [3:0]  araddr,   // Read address
   input  wire logic        arvalid,  // Read address valid
   output logic             arready,  // Read address ready
   output logic [31:0]      rdata,    // Read data
   output logic [1:0]       rresp,    // Read response
   output logic             rvalid,   // Read valid
   input  wire logic        rready,   // Read ready
   output logic             wr_en,    // Write pulse
   output logic [3:0]       wr_addr,  // Write offset
   output logic [7:0]       wr_byte,  // Low write byte
   output logic             rd_en,    // Read pulse
   output logic [3:0]       rd_addr,  // Read offset
   input  wire logic [7:0]  rd_byte,  // Read byte
   input  wire logic        rd_ok     // Read offset mapped
);
   logic aw_held;
   logic w_held;
   logic wr_ok;
   wire  aw_take = awvalid && awready;
   wire  w_take  = wvalid && wready;
   wire  both    = (aw_held || aw_take) && (w_held || w_take) && !bvalid;
   wire  wr_map  = (awaddr[1:0] == 2'h0);
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         awready <= 1'b1;
         wready  <= 1'b1;
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         bvalid  <= 1'b0;
         bresp   <= pps_pkg::AXI_OKAY;
         wr_en   <= 1'b0;
         wr_addr <= 4'h0;
         wr_byte <= 8'h00;
         wr_ok   <= 1'b0;
      end else begin
         wr_en <= 1'b0;
         if (aw_take) begin
            wr_addr <= awaddr;
            wr_ok   <= wr_map;
            awready <= 1'b0;
            aw_held <= 1'b1;
         end
         if (w_take) begin
            // Registers are one byte; only lane 0 counts
            wr_byte <= wstrb[0] ? wdata[7:0] : 8'h00;
            wready  <= 1'b0;
            w_held  <= wstrb[0];
         end
         if (aw_held && w_held && !bvalid) begin
            wr_en   <= wr_ok;
            bvalid  <= 1'b1;
            bresp   <= wr_ok ? pps_pkg::AXI_OKAY : pps_pkg::AXI_SLVERR;
            aw_held <= 1'b0;
            w_held  <= 1'b0;
         end else if (bvalid && bready) begin
            bvalid  <= 1'b0;
            awready <= 1'b1;
            wready  <= 1'b1;
         end
         if (w_take && !wstrb[0]) begin
            w_held <= 1'b1;
            wr_byte <= 8'h00;
         end
      end
   end
   logic rd_wait;
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         arready <= 1'b1;
         rvalid  <= 1'b0;
         rdata   <= 32'h0000_0000;
         rresp   <= pps_pkg::AXI_OKAY;
         rd_en   <= 1'b0;
         rd_addr <= 4'h0;
         rd_wait <= 1'b0;
      end else begin
         rd_en <= 1'b0;
         if (arvalid && arready) begin
            rd_addr <= araddr;
            rd_en   <= 1'b1;
            rd_wait <= 1'b1;
            arready <= 1'b0;
         end else if (rd_wait) begin
            rd_wait <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= {24'h00_0000, rd_ok ? rd_byte : 8'h00};
            rresp   <= rd_ok ? pps_pkg::AXI_OKAY : pps_pkg::AXI_SLVERR;
         end else if (rvalid && rready) begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
         end
      end
   end
   wire unused = both;
endmodule
`default_nettype wire

//--- design/pps_pin.sv
`default_nettype none
module pps_pin (
   input  wire logic clk_sys,  // System clock
   input  wire logic nrst,     // Sync reset, low
   input  wire logic level,    // Level to drive
   input  wire logic drive,    // Drive enable
   output logic      pin_o,    // Pin output
   output logic      pin_oe    // Pin output enable
);
   // Registered so top outputs come straight from flops
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         pin_o  <= 1'b1;
         pin_oe <= 1'b0;
      end else begin
         pin_o  <= level;
         pin_oe <= drive;
      end
   end
endmodule
`default_nettype wire

//--- dv/pps_printer_model.sv
`default_nettype none
module pps_printer_model (
   input  wire logic       clk_sys,                // System clock
   input  wire logic       enhanced_parallel_mode,                    // Enhanced handshake in use
   input  wire logic       strobe_n,               // Either strobe, wire level
   input  wire logic [31:0] wait_dly,              // Cycles until wait released
   input  wire logic [4:0] lv,                     // Busy, ack, paper, sel, err
   input  wire logic [7:0] peri_byte,              // Byte the peripheral offers
   input  wire logic       host_oe,                // Host drives data lines
   input  wire logic [7:0] host_o,                 // Host data
   output logic [7:0]      lines,                  // Resolved data lines
   output logic            ack_n,                  // Acknowledge
   output logic            busy_or_wait_n,         // Busy or wait
   output logic            error_n,                // Error
   output logic            paper_out_input,        // Paper out
   output logic            printer_selected_input  // Selected
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt = 0;
   always @(posedge clk_sys) begin
      if (strobe_n)
         cnt <= 0;
      else
         cnt <= cnt + 1;
   end
   // Wait held low until ready; a delay past the host limit forces a timeout
   assign busy_or_wait_n = enhanced_parallel_mode ? (!strobe_n && cnt >= wait_dly) : lv[4];
   assign ack_n = lv[3];
   assign paper_out_input = lv[2];
   assign printer_selected_input = lv[1];
   assign error_n = lv[0];
   // Peripheral drives the lines whenever the host lets go
   assign lines = host_oe ? host_o : peri_byte;
endmodule
`default_nettype wire

//--- dv/parallel_port_signalling_tb.sv
`default_nettype none
module parallel_port_signalling_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys = 1'b0, nrst = 1'b0, enhanced_parallel_mode = 1'b0;
   logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic [7:0] lines, data_o, peri_byte = 8'h00;
   logic data_oe, fd_o, fd_oe, sa_o, sa_oe, vw_o, vw_oe, in_o, in_oe;
   logic ack_n, wait_n, error_n, paper, selected;
   logic [4:0] lv = 5'h1f;
   int wait_dly = 0, bad_count = 0, checked = 0, seed = 32'h344b, n;
   logic [33:0] exp_q[$], msk_q[$];
   logic [1:0] br;
   logic [7:0] x;
   // Wire levels with the external pull-ups
   wire feed_lv = fd_oe ? fd_o : 1'b1;
   wire sel_lv = sa_oe ? sa_o : 1'b1;
   wire valid_lv = vw_oe ? vw_o : 1'b1;
   always #50 clk_sys = ~clk_sys;
   pps_top #(.WAIT_MAX(8'h08)) uut (.clk_sys(clk_sys), .nrst(nrst),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .port_data_lines_i(lines),
      .port_data_lines_o(data_o), .port_data_lines_oe(data_oe), .feed_or_data_strobe_pin_o(fd_o),
      .feed_or_data_strobe_pin_oe(fd_oe), .select_or_address_strobe_pin_o(sa_o),
      .select_or_address_strobe_pin_oe(sa_oe), .valid_or_write_strobe_pin_o(vw_o),
      .valid_or_write_strobe_pin_oe(vw_oe), .init_pin_o(in_o), .init_pin_oe(in_oe), .ack_n(ack_n),
      .busy_or_wait_n(wait_n), .error_n(error_n), .paper_out_input(paper),
      .printer_selected_input(selected));
   pps_printer_model peri (.clk_sys(clk_sys), .enhanced_parallel_mode(enhanced_parallel_mode), .strobe_n(feed_lv & sel_lv), .wait_dly(wait_dly),
      .lv(lv), .peri_byte(peri_byte), .host_oe(data_oe), .host_o(data_o), .lines(lines), .ack_n(ack_n),
      .busy_or_wait_n(wait_n), .error_n(error_n), .paper_out_input(paper),
      .printer_selected_input(selected));
   task automatic check(input logic [33:0] got, input logic [33:0] exp);
      checked++;
      if (got !== exp) begin
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
         bad_count++;
      end
   endtask
   task automatic give_verdict();
      $display("compares=%0d mismatches=%0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic axw(input logic [3:0] a, input logic [7:0] d, output logic [1:0] resp);
      int k;
      k = 0;
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk_sys);
         k++;
         resp = s_axi_bresp;
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid && k < 50);
      if (k >= 50)
         bad_count++;
      s_axi_bready <= 1'b0;
      @(posedge clk_sys);
   endtask
   // Expected read result goes on the queue; the monitor below compares it
   task automatic axr(input logic [3:0] a, input logic [33:0] e, input logic [33:0] m);
      int k;
      k = 0;
      exp_q.push_back(e);
      msk_q.push_back(m);
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk_sys);
         k++;
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid && k < 50);
      if (k >= 50)
         bad_count++;
      s_axi_rready <= 1'b0;
      @(posedge clk_sys);
   endtask
   always @(posedge clk_sys) begin
      if (s_axi_rvalid && s_axi_rready && exp_q.size() > 0) begin
         check({s_axi_rresp, s_axi_rdata} & msk_q[0], exp_q[0] & msk_q[0]);
         void'(exp_q.pop_front());
         void'(msk_q.pop_front());
      end
   end
   task automatic cyc(input logic [7:0] cmd, input int dly, input logic [7:0] d, output int cnt);
      wait_dly <= dly;
      axw(pps_pkg::ADDR_EPP, cmd, br);
      cnt = 0;
      repeat (40) begin
         @(negedge clk_sys);
         if (!(feed_lv && sel_lv)) begin
            cnt++;
            check({feed_lv, sel_lv, valid_lv, data_oe, cmd[1] ? data_o : 8'h00},
                  {cmd[2] ? 2'b10 : 2'b01, !cmd[1], cmd[1], cmd[1] ? d : 8'h00});
         end
      end
   endtask
   initial begin
      #2_000_000;
      bad_count++;
      give_verdict();
   end
   initial begin
      repeat (3) @(posedge clk_sys);
      nrst <= 1'b1;
      repeat (2) @(negedge clk_sys);
      check({fd_oe, sa_oe, vw_oe, in_oe, data_oe}, 5'h01);
      axr(pps_pkg::ADDR_CTRL, {2'h0, 24'h0, pps_pkg::CTRL_RESET}, 34'h3_ffff_ffff);
      $display("test reset done");
      for (int b = 0; b < 4; b++) begin
         axw(pps_pkg::ADDR_CTRL, pps_pkg::CTRL_RESET ^ (8'h01 << b), br);
         repeat (3) @(negedge clk_sys);
         check({sa_oe, in_oe, fd_oe, vw_oe, sel_lv & feed_lv & valid_lv & (in_oe ? in_o : 1'b1)},
               {4'h1 << b, 1'b0});
      end
      $display("test compat pins done");
      repeat (3) begin
         lv <= 5'($random(seed));
         repeat (5) @(posedge clk_sys);
         axr(pps_pkg::ADDR_STATUS, {2'h0, 24'h0, lv, 3'b000}, 34'h3_0000_00ff);
      end
      x = 8'($random(seed));
      axw(pps_pkg::ADDR_DATA, x, br);
      repeat (3) @(negedge clk_sys);
      check({data_oe, data_o}, {1'b1, x});
      axw(4'h1, 8'h55, br);
      check(br, pps_pkg::AXI_SLVERR);
      peri_byte <= 8'($random(seed));
      axw(pps_pkg::ADDR_CTRL, 8'h20, br);
      repeat (3) @(negedge clk_sys);
      check(data_oe, 1'b0);
      axr(pps_pkg::ADDR_DATA, {2'h0, 24'h0, peri_byte}, 34'h3_0000_00ff);
      $display("test data lines done");
      enhanced_parallel_mode <= 1'b1;
      peri_byte <= ~peri_byte;
      axw(pps_pkg::ADDR_CTRL, 8'h80, br);
      for (int i = 0; i < 4; i++) begin
         cyc({5'h00, 1'(i[0]), ~1'(i[1]), 1'b1}, 2 + i, x, n);
         check(n >= 2 + i && n <= 6 + i, 1'b1);
      end
      // Last read cycle must have caught the peripheral's new byte
      axr(pps_pkg::ADDR_DATA, {2'h0, 24'h0, peri_byte}, 34'h3_0000_00ff);
      cyc(8'h03, 30, x, n);
      check(n >= 8 && n <= 10, 1'b1);
      axr(pps_pkg::ADDR_STATUS, {2'h0, 24'h0, 8'h04}, 34'h3_0000_0006);
      wait_dly <= 60;
      axw(pps_pkg::ADDR_EPP, 8'h03, br);
      axw(pps_pkg::ADDR_EPP, 8'h08, br);
      repeat (3) @(negedge clk_sys);
      check({feed_lv, sel_lv, valid_lv}, 3'b111);
      axr(pps_pkg::ADDR_STATUS, 34'h0, 34'h3_0000_0006);
      axw(pps_pkg::ADDR_EPP, 8'h05, br);
      axw(pps_pkg::ADDR_CTRL, 8'h00, br);
      repeat (3) @(negedge clk_sys);
      check({feed_lv, sel_lv, valid_lv}, 3'b111);
      axr(pps_pkg::ADDR_STATUS, 34'h0, 34'h3_0000_0002);
      $display("test enhanced cycles done");
      give_verdict();
   end
endmodule
`default_nettype wire
